// ==== src/dtse_pkg.sv ====
/*
  Shared constants and types of the dual-tone sequence encoder:
  register map, field positions, reset values, timing and carriers.
  Assumes a single 10 MHz clock domain.
*/
`default_nettype none

package dtse_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ON_MS = 8'h08;
  localparam logic [7:0] REG_OFF_MS = 8'h0c;
  localparam logic [7:0] REG_BURSTS = 8'h10;
  localparam logic [7:0] REG_SEQ_LAST = 8'h14;
  localparam logic [7:0] REG_TWIST = 8'h18;
  localparam logic [7:0] REG_LEVEL = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [2:0] REG_FREQ_PAGE = 3'h2;  // 0x40..0x5c, addr[7:5]
  localparam logic [1:0] REG_SYM_PAGE = 2'h2;   // 0x80..0xbc, addr[7:6]

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;  // two bits
  localparam int CTRL_PRE_EMP = 2;
  localparam int CTRL_ROUTE_AUDIO = 3;
  localparam int CTRL_AUDIO_DC = 4;
  localparam int CTRL_DC_FM = 5;
  localparam int CTRL_W = 6;
  localparam int CMD_SEND = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_STD = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] ON_MS_RST = 16'h0032;
  localparam logic [15:0] OFF_MS_RST = 16'h0032;
  localparam logic [15:0] BURSTS_RST = 16'h0001;
  localparam logic [3:0] SEQ_LAST_RST = 4'h0;
  localparam logic [15:0] TWIST_RST = 16'h0000;
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  localparam logic [7:0][15:0] FREQ_PRESET = {
    16'h0661, 16'h05c5, 16'h0538, 16'h04b9,   // column tones
    16'h03ad, 16'h0354, 16'h0302, 16'h02b9};  // row tones

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int PRE_EMP_DB10_PER_OCT = 60;  // 6 dB per octave, 0.1 dB units

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {MODE_SINGLE, MODE_BURST, MODE_CONT, MODE_STEP} dtse_mode_t;

  typedef struct packed {
    logic on;
    logic route_audio;
    logic [15:0] row_hz;
    logic [15:0] col_hz;
  } dtse_tone_t;

  typedef struct packed {
    logic [15:0] peak;
    logic signed [15:0] diff_db10;
  } dtse_level_t;

endpackage

`default_nettype wire

// ==== src/dtse_sym_mem.sv ====
/*
  Symbol sequence store: one write port from the register bus,
  one read port with registered data.
  Assumes write and read on the same clock.
*/
`default_nettype none

module dtse_sym_mem #(
  parameter int DEPTH = 16,
  parameter int W = 4
) (
  input wire logic i_clk,                       // system clock
  input wire logic i_we,                        // write strobe
  input wire logic [$clog2(DEPTH)-1:0] i_waddr, // write index
  input wire logic [W-1:0] i_wdata,             // symbol code
  input wire logic [$clog2(DEPTH)-1:0] i_raddr, // read index
  output logic [W-1:0] o_rdata                  // registered symbol
);

  if (DEPTH < 2) begin : g_bad_depth
    $error("dtse_sym_mem: DEPTH below 2");
  end

  logic [W-1:0] mem [DEPTH];

  // ------------------------------------------------------------
  // storage; no reset, contents are software's to define
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_raddr];
  end

endmodule

`default_nettype wire

// ==== src/dtse_level_calc.sv ====
/*
  Level split of the tone pair: twist plus pre-emphasis slope give
  the high-over-low difference in 0.1 dB, peak stays programmed level.
  Assumes frequencies in Hz, one clock of latency is acceptable.
*/
`default_nettype none

module dtse_level_calc (
  input wire logic i_clk,                   // system clock
  input wire logic i_rst_n,                 // synchronised reset, low
  input wire dtse_pkg::dtse_tone_t i_tone,  // current tone pair
  input wire logic [15:0] i_twist,          // signed, 0.1 dB
  input wire logic i_pre_emp,               // pre-emphasis path chosen
  input wire logic [15:0] i_level,          // programmed peak
  output dtse_pkg::dtse_level_t o_level     // registered levels
);

  // log2 as q4.8: msb position plus linear mantissa, good to ~0.5 dB
  function automatic logic [11:0] log2_q(input logic [15:0] x);
    logic [3:0] p;
    logic [15:0] n;
    p = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (x[i]) begin
        p = 4'(i);
      end
    end
    n = x << (4'hf - p);
    return {p, n[14:7]};
  endfunction

  logic signed [12:0] oct_q;
  logic signed [21:0] slope;
  logic signed [15:0] pre_db10;

  // ------------------------------------------------------------
  // slope of 6 dB per octave of col/row ratio
  // ------------------------------------------------------------
  always_comb begin
    oct_q = $signed({1'b0, log2_q(i_tone.col_hz)}) - $signed({1'b0, log2_q(i_tone.row_hz)});
    slope = 22'(oct_q) * 22'(dtse_pkg::PRE_EMP_DB10_PER_OCT);
    pre_db10 = i_pre_emp ? 16'(slope >>> 8) : 16'h0000;
  end

  // sum in dB; peak untouched so the pair's sum keeps the level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= '0;
    end else begin
      o_level.diff_db10 <= $signed(i_twist) + pre_db10;
      o_level.peak <= i_level;
    end
  end

endmodule

`default_nettype wire

// ==== src/dtse_encoder.sv ====
/*
  Dual-tone sequence encoder top: register slave, sequencer, routing.
  Assumes a plain register port on the same clock as i_clk and a
  downstream synthesiser that turns tone pair plus levels into audio.
*/
// Added by the designer: the address-and-strobe port and the placing of the registers.
`default_nettype none

// Contract
// - each tone pair stays on for the programmed on-time
// - silence of the programmed off-time between tone pairs
// - send starts the sequence in the selected repetition mode
// - single mode sends the whole sequence once, then idles
// - burst mode repeats the sequence the programmed burst count
// - continuous mode repeats until a stop arrives
// - step mode sends one next tone pair per send
// - stop ends the sequence in progress
// - standard select loads all eight frequencies, each still editable
// - twist sets high-over-low level ratio in dB, signed
// - pre-emphasis select routes signal through or around the network
// - pre-emphasis adds 6 dB per octave between high and low tones
// - twist and pre-emphasis differences add in dB
// - programmed level is the peak of the summed pair
// - route picks modulator or audio port; level zero means off
// - audio coupling selects ac or dc to the audio port
// - fm coupling enables dc fm and picks input coupling

module dtse_encoder #(
  parameter int CYC_PER_MS = dtse_pkg::CYC_PER_MS,
  parameter logic [7:0][15:0] FREQ_PRESET = dtse_pkg::FREQ_PRESET
) (
  input wire logic i_clk,                   // 10 MHz clock
  input wire logic i_resetn,                // async reset, low
  input wire logic [7:0] i_addr,            // register byte address
  input wire logic [31:0] i_wdata,          // write data
  input wire logic i_wr,                    // write strobe
  input wire logic i_rd,                    // read strobe
  output logic [31:0] o_rdata,              // read data, next cycle
  output dtse_pkg::dtse_tone_t o_tone,      // tone pair and route
  output dtse_pkg::dtse_level_t o_level,    // peak and dB difference
  output logic o_pre_emp_sel,               // through pre-emphasis
  output logic o_audio_dc,                  // audio port dc coupled
  output logic o_dc_coupled_fm,             // dc fm, dc input coupling
  output logic o_busy                       // sequence in progress
);

  if (CYC_PER_MS < 2) begin : g_bad_cyc
    $error("dtse_encoder: CYC_PER_MS below 2");
  end

  localparam int PW = $clog2(CYC_PER_MS);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  logic [5:0] ctrl;
  logic [15:0] on_ms;
  logic [15:0] off_ms;
  logic [15:0] bursts;
  logic [3:0] seq_last;
  logic [15:0] twist;
  logic [15:0] level;
  logic [7:0][15:0] freq;
  logic send;
  logic stop;
  logic load_std;
  logic sym_we;
  dtse_pkg::dtse_mode_t mode;

  assign send = i_wr && hit(i_addr, dtse_pkg::REG_CMD) && i_wdata[dtse_pkg::CMD_SEND];
  assign stop = i_wr && hit(i_addr, dtse_pkg::REG_CMD) && i_wdata[dtse_pkg::CMD_STOP];
  assign load_std = i_wr && hit(i_addr, dtse_pkg::REG_CMD) && i_wdata[dtse_pkg::CMD_STD];
  assign sym_we = i_wr && (i_addr[7:6] == dtse_pkg::REG_SYM_PAGE);
  assign mode = dtse_pkg::dtse_mode_t'(ctrl[dtse_pkg::CTRL_MODE_LSB +: 2]);

  // settings; changed on_ms and off_ms take effect at the next on or off interval
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= dtse_pkg::CTRL_RST;
      on_ms <= dtse_pkg::ON_MS_RST;
      off_ms <= dtse_pkg::OFF_MS_RST;
      bursts <= dtse_pkg::BURSTS_RST;
      seq_last <= dtse_pkg::SEQ_LAST_RST;
      twist <= dtse_pkg::TWIST_RST;
      level <= dtse_pkg::LEVEL_RST;
    end else if (i_wr) begin
      if (hit(i_addr, dtse_pkg::REG_CTRL)) ctrl <= i_wdata[dtse_pkg::CTRL_W-1:0];
      if (hit(i_addr, dtse_pkg::REG_ON_MS)) on_ms <= i_wdata[15:0];
      if (hit(i_addr, dtse_pkg::REG_OFF_MS)) off_ms <= i_wdata[15:0];
      if (hit(i_addr, dtse_pkg::REG_BURSTS)) bursts <= i_wdata[15:0];
      if (hit(i_addr, dtse_pkg::REG_SEQ_LAST)) seq_last <= i_wdata[3:0];
      if (hit(i_addr, dtse_pkg::REG_TWIST)) twist <= i_wdata[15:0];
      if (hit(i_addr, dtse_pkg::REG_LEVEL)) level <= i_wdata[15:0];
    end
  end

  // frequency table; standard load wins over a same-cycle edit
  for (genvar g = 0; g < 8; g++) begin : g_freq
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        freq[g] <= FREQ_PRESET[g];
      end else if (load_std) begin
        freq[g] <= FREQ_PRESET[g];
      end else if (i_wr && i_addr[7:5] == dtse_pkg::REG_FREQ_PAGE && i_addr[4:2] == 3'(g)) begin
        freq[g] <= i_wdata[15:0];
      end
    end
  end

  // coupling and path selects go straight out from the control word
  assign o_pre_emp_sel = ctrl[dtse_pkg::CTRL_PRE_EMP];
  assign o_audio_dc = ctrl[dtse_pkg::CTRL_AUDIO_DC];
  assign o_dc_coupled_fm = ctrl[dtse_pkg::CTRL_DC_FM];

  // ------------------------------------------------------------
  // symbol store
  // ------------------------------------------------------------
  logic [3:0] idx;
  logic [3:0] sym;

  dtse_sym_mem #(.DEPTH(16), .W(4)) u_mem (
    .i_clk(i_clk),
    .i_we(sym_we),
    .i_waddr(i_addr[5:2]),
    .i_wdata(i_wdata[3:0]),
    .i_raddr(idx),
    .o_rdata(sym)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF} dtse_state_t;

  dtse_state_t st;
  dtse_state_t next_st;
  logic [PW-1:0] pre_cnt;
  logic [15:0] ms_left;
  logic [15:0] rep_left;
  logic tick;
  logic done;
  logic at_end;
  logic last_pass;

  assign tick = pre_cnt == PW'(CYC_PER_MS - 1);
  assign done = tick && ms_left == 16'h0001;
  assign at_end = idx == seq_last;
  assign last_pass = at_end && (mode == dtse_pkg::MODE_SINGLE ||
                                (mode == dtse_pkg::MODE_BURST && rep_left == 16'h0000));

  // state choice; sends while busy are ignored
  always_comb begin
    next_st = st;
    unique case (st)
      ST_IDLE: if (send && !stop) next_st = ST_ON;
      ST_ON: begin
        if (stop) next_st = ST_IDLE;
        else if (done && (mode == dtse_pkg::MODE_STEP || last_pass)) next_st = ST_IDLE;
        else if (done) next_st = ST_OFF;
      end
      ST_OFF: begin
        if (stop) next_st = ST_IDLE;
        else if (done) next_st = ST_ON;
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) st <= ST_IDLE;
    else st <= next_st;
  end

  // interval timer: millisecond prescaler restarted on every state change;
  // zero durations run one millisecond so the sequence always advances
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= '0;
      ms_left <= 16'h0001;
    end else if (next_st != st) begin
      pre_cnt <= '0;
      if (next_st == ST_ON) ms_left <= (on_ms == 16'h0000) ? 16'h0001 : on_ms;
      else ms_left <= (off_ms == 16'h0000) ? 16'h0001 : off_ms;
    end else if (tick) begin
      pre_cnt <= '0;
      ms_left <= ms_left - 16'h0001;
    end else begin
      pre_cnt <= pre_cnt + PW'(1);
    end
  end

  // symbol position; step mode keeps it across idle to resume there
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) idx <= 4'h0;
    else if (stop) idx <= 4'h0;
    else if (st == ST_ON && done) idx <= at_end ? 4'h0 : idx + 4'h1;
  end

  // remaining repetitions; a count of zero behaves as one
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_left <= 16'h0000;
    end else if (st == ST_IDLE && send) begin
      rep_left <= (bursts == 16'h0000) ? 16'h0000 : bursts - 16'h0001;
    end else if (st == ST_ON && done && at_end && rep_left != 16'h0000) begin
      rep_left <= rep_left - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // tone follows next state so a stop silences on the following edge
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tone <= '0;
      o_busy <= 1'b0;
    end else begin
      o_tone.on <= next_st == ST_ON && level != 16'h0000;
      o_tone.route_audio <= ctrl[dtse_pkg::CTRL_ROUTE_AUDIO];
      o_tone.row_hz <= freq[{1'b0, sym[3:2]}];
      o_tone.col_hz <= freq[{1'b1, sym[1:0]}];
      o_busy <= next_st != ST_IDLE;
    end
  end

  dtse_level_calc u_lvl (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_tone(o_tone),
    .i_twist(twist),
    .i_pre_emp(ctrl[dtse_pkg::CTRL_PRE_EMP]),
    .i_level(level),
    .o_level(o_level)
  );

  // read data only in the cycle after the strobe; holes read zero
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_addr[7:5] == dtse_pkg::REG_FREQ_PAGE) rd_mux = {16'h0000, freq[i_addr[4:2]]};
    else if (hit(i_addr, dtse_pkg::REG_CTRL)) rd_mux = {26'h0, ctrl};
    else if (hit(i_addr, dtse_pkg::REG_ON_MS)) rd_mux = {16'h0000, on_ms};
    else if (hit(i_addr, dtse_pkg::REG_OFF_MS)) rd_mux = {16'h0000, off_ms};
    else if (hit(i_addr, dtse_pkg::REG_BURSTS)) rd_mux = {16'h0000, bursts};
    else if (hit(i_addr, dtse_pkg::REG_SEQ_LAST)) rd_mux = {28'h0, seq_last};
    else if (hit(i_addr, dtse_pkg::REG_TWIST)) rd_mux = {16'h0000, twist};
    else if (hit(i_addr, dtse_pkg::REG_LEVEL)) rd_mux = {16'h0000, level};
    else if (hit(i_addr, dtse_pkg::REG_STATUS)) rd_mux = {rep_left, 8'h00, idx, 2'b00, st};
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_rdata <= 32'h0000_0000;
    else o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [31:0] run_cnt;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) run_cnt <= 32'h0;
    else if (next_st != st) run_cnt <= 32'h0;
    else run_cnt <= run_cnt + 32'h1;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_send_idle;
    st == ST_IDLE && send && !stop;
  endsequence

  sequence s_on_end;
    st == ST_ON && done && !stop;
  endsequence

  on_hold_a: assert property (s_on_end |-> run_cnt ==
    32'((on_ms == 16'h0 ? 32'h1 : 32'(on_ms)) * 32'(CYC_PER_MS)) - 32'h1)
    else $error("on interval length wrong");
  off_hold_a: assert property (st == ST_OFF && done && !stop |-> run_cnt ==
    32'((off_ms == 16'h0 ? 32'h1 : 32'(off_ms)) * 32'(CYC_PER_MS)) - 32'h1)
    else $error("off interval length wrong");
  send_start_a: assert property (s_send_idle |=> st == ST_ON && o_busy)
    else $error("send did not start sequence");
  single_end_a: assert property (s_on_end ##0 (mode == dtse_pkg::MODE_SINGLE) |=>
    (st == ST_IDLE) == $past(at_end))
    else $error("single mode end wrong");
  burst_load_a: assert property (s_send_idle ##0 (bursts > 16'h1) |=>
    rep_left == $past(bursts) - 16'h1)
    else $error("burst count not loaded");
  cont_run_a: assert property (st != ST_IDLE && mode == dtse_pkg::MODE_CONT && !stop
    |=> st != ST_IDLE)
    else $error("continuous mode stopped by itself");
  step_one_a: assert property (s_on_end ##0 (mode == dtse_pkg::MODE_STEP) |=>
    st == ST_IDLE && idx == ($past(at_end) ? 4'h0 : $past(idx) + 4'h1))
    else $error("step mode did not advance one");
  stop_idle_a: assert property (stop |=> st == ST_IDLE && !o_tone.on && idx == 4'h0)
    else $error("stop did not silence");
  tone_gate_a: assert property (o_tone.on |-> st == ST_ON && $past(level) != 16'h0)
    else $error("tone on outside on interval");

endmodule

`default_nettype wire

// ==== test/dtse_tone_sink.sv ====
/*
  Far-side model: the modulator or audio port that takes the tone pair.
  Assumes the encoder clock; counts pairs and measures on and off runs.
*/
`default_nettype none

module dtse_tone_sink (
  input wire logic i_clk,                 // encoder clock
  input wire logic i_clr,                 // clear the pair count
  input wire dtse_pkg::dtse_tone_t i_tone, // tone pair seen
  output logic [15:0] o_pairs,            // pairs started
  output logic [15:0] o_on_len,           // last on run, cycles
  output logic [15:0] o_gap_len,          // last gap between pairs
  output logic [15:0] o_row,              // row tone of last pair
  output logic [15:0] o_col               // column tone of last pair
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  logic [15:0] run = 16'h0000;

  // run lengths latched on each change; the gap before the first pair is not a gap
  always_ff @(posedge i_clk) begin
    prev <= i_tone.on;
    run <= (i_tone.on != prev) ? 16'h0001 : run + 16'h0001;
    if (i_tone.on && !prev) begin
      o_pairs <= o_pairs + 16'h0001;
      o_row <= i_tone.row_hz;
      o_col <= i_tone.col_hz;
      if (o_pairs != 16'h0000) o_gap_len <= run;
    end
    if (!i_tone.on && prev) o_on_len <= run;
    if (i_clr) o_pairs <= 16'h0000;
  end
endmodule

`default_nettype wire

// ==== test/dtse_encoder_tb.sv ====
/*
  Self-checking bench of the tone sequence encoder.
  Assumes CYC_PER_MS shortened to 4 and the far-side sink model.
*/
`default_nettype none

`define CHK(nm, e, g) \
  begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end

module dtse_encoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ON_CYC = 16'h0004;   // 1 ms at 4 cycles per ms
  localparam logic [15:0] GAP_CYC = 16'h0008;  // 2 ms
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_clr = 1'b0;
  logic [31:0] o_rdata;
  dtse_pkg::dtse_tone_t o_tone;
  dtse_pkg::dtse_level_t o_level;
  logic o_pre_emp_sel, o_audio_dc, o_dc_coupled_fm, o_busy;
  logic [15:0] pairs, on_len, gap_len, row, col;
  int fails = 0;
  int check_count = 0;

  always #50 i_clk = ~i_clk;

  dtse_encoder #(.CYC_PER_MS(4)) uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tone(o_tone),
    .o_level(o_level), .o_pre_emp_sel(o_pre_emp_sel), .o_audio_dc(o_audio_dc),
    .o_dc_coupled_fm(o_dc_coupled_fm), .o_busy(o_busy));

  dtse_tone_sink sink (.i_clk(i_clk), .i_clr(i_clr), .i_tone(o_tone), .o_pairs(pairs),
    .o_on_len(on_len), .o_gap_len(gap_len), .o_row(row), .o_col(col));

  // ------------------------------------------------------------
  // bus and wait helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 `CHK("rdata", e, o_rdata)
  endtask

  task automatic send(input logic [31:0] ctrl);
    wr(dtse_pkg::REG_CTRL, ctrl);
    @(posedge i_clk);
    i_clr <= 1'b1;
    @(posedge i_clk);
    i_clr <= 1'b0;
    wr(dtse_pkg::REG_CMD, 32'h1);
  endtask

  // bounded waits so a stuck sequencer cannot hang the run
  task automatic wait_idle;
    int n = 0;
    @(posedge i_clk);
    #1;
    while (o_busy !== 1'b0 && n < 3000) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 3000) fails++;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic wait_on;
    int n = 0;
    while (o_tone.on !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 50) fails++;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic give_verdict;
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd_chk(dtse_pkg::REG_ON_MS, 32'h32);
    rd_chk(dtse_pkg::REG_BURSTS, 32'h1);
    rd_chk(8'h5c, {16'h0, dtse_pkg::FREQ_PRESET[7]});
    rd_chk(8'h30, 32'h0);
    rd_chk(dtse_pkg::REG_CMD, 32'h0);
  endtask

  task automatic t_controls;
    for (int b = 2; b < 6; b++) begin
      wr(dtse_pkg::REG_CTRL, 32'h1 << b);
      repeat (2) @(posedge i_clk);
      #1 `CHK("ctl", 4'h1 << (b - 2), {o_dc_coupled_fm, o_audio_dc, o_tone.route_audio, o_pre_emp_sel})
    end
  endtask

  task automatic t_single;
    send(32'h0);
    wait_idle;
    `CHK("pairs", 16'h0002, pairs)
    `CHK("on_len", ON_CYC, on_len)
    `CHK("gap_len", GAP_CYC, gap_len)
    `CHK("row", dtse_pkg::FREQ_PRESET[1], row)
    `CHK("col", dtse_pkg::FREQ_PRESET[7], col)
    `CHK("on", 1'b0, o_tone.on)
  endtask

  task automatic t_burst;
    wr(dtse_pkg::REG_BURSTS, 32'h3);
    send(32'h1);
    wait_idle;
    `CHK("pairs", 16'h0006, pairs)
  endtask

  task automatic t_cont;
    send(32'h2);
    repeat (150) @(posedge i_clk);
    #1 `CHK("busy", 1'b1, o_busy)
    `CHK("many", 1'b1, pairs > 16'h0004)
    wr(dtse_pkg::REG_CMD, 32'h2);
    @(posedge i_clk);
    #1 `CHK("busy", 1'b0, o_busy)
    `CHK("on", 1'b0, o_tone.on)
  endtask

  task automatic t_step;
    send(32'h3);
    wait_idle;
    `CHK("pairs", 16'h0001, pairs)
    `CHK("row", dtse_pkg::FREQ_PRESET[0], row)
    wr(dtse_pkg::REG_CMD, 32'h1);
    wait_idle;
    `CHK("pairs", 16'h0002, pairs)
    `CHK("row", dtse_pkg::FREQ_PRESET[1], row)
  endtask

  // one octave apart, so the slope is exactly 6 dB
  task automatic t_levels;
    wr(8'h40, 32'h200);
    wr(8'h50, 32'h400);
    rd_chk(8'h40, 32'h200);
    wr(dtse_pkg::REG_TWIST, 32'h19);
    send(32'h7);
    wait_on;
    `CHK("peak", 16'h0100, o_level.peak)
    `CHK("diff", 16'h0055, o_level.diff_db10)
    wait_idle;
    wr(dtse_pkg::REG_TWIST, 32'hffe7);
    send(32'h3);
    wait_on;
    `CHK("diff", 16'hffe7, o_level.diff_db10)
    wait_idle;
    wr(dtse_pkg::REG_CMD, 32'h4);
    rd_chk(8'h40, {16'h0, dtse_pkg::FREQ_PRESET[0]});
    rd_chk(8'h50, {16'h0, dtse_pkg::FREQ_PRESET[4]});
  endtask

  task automatic t_off;
    wr(dtse_pkg::REG_LEVEL, 32'h0);
    send(32'h0);
    wait_idle;
    `CHK("pairs", 16'h0000, pairs)
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_regs;
    t_controls;
    wr(dtse_pkg::REG_LEVEL, 32'h100);
    wr(dtse_pkg::REG_ON_MS, 32'h1);
    wr(dtse_pkg::REG_OFF_MS, 32'h2);
    wr(dtse_pkg::REG_SEQ_LAST, 32'h1);
    wr(8'h80, 32'h0);
    wr(8'h84, 32'h7);
    t_single;
    t_burst;
    t_cont;
    t_step;
    t_levels;
    t_off;
    give_verdict;
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (30000) @(posedge i_clk);
    fails++;
    give_verdict;
  end
endmodule

`default_nettype wire
